// File: bsoe_pkg.sv
// package with opcodes, field positions, reset values and states of the executor
package bsoe_pkg;
   localparam int INSTR_W = 14;
   localparam int PC_W = 15;
   localparam int FILE_AW = 7;
   localparam int DATA_W = 8;
   localparam int LATCH_W = 7;
   // field positions
   localparam int DEST_BIT = 7;
   localparam int FILE_ADDR_MSB = 6;
   localparam int LIT8_MSB = 7;
   localparam int LIT11_MSB = 10;
   localparam int LATCH_HI_MSB = 6;
   localparam int LATCH_HI_LSB = 3;
   // opcode matching: upper six bits for file ops, upper three for the jump
   localparam logic [5:0] OP_DECREMENT_SKIP_ZERO = 6'h0B;
   localparam logic [5:0] OP_INCREMENT_SKIP_ZERO = 6'h0F;
   localparam logic [5:0] OP_INCREMENT_FILE = 6'h0A;
   localparam logic [5:0] OP_OR_WORK_WITH_FILE = 6'h04;
   localparam logic [5:0] OP_OR_LITERAL_INTO_WORK = 6'h38;
   localparam logic [2:0] OP_JUMP_ABSOLUTE = 3'h5;
   // reset values
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic [1:0] CYCLES_RESET = 2'h0;
   localparam logic PULSE_RESET = 1'b0;
   localparam logic READY_RESET = 1'b1;
   // cycle counts reported per instruction
   localparam logic [1:0] CYCLES_ONE = 2'h1;
   localparam logic [1:0] CYCLES_TWO = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_OPERAND = 3'b010,
      ST_EXTRA = 3'b100
   } bsoe_state_e;

   function automatic logic bsoe_is_zero(input logic [DATA_W-1:0] v);
      return (v == 8'h00);
   endfunction
endpackage

// File: bsoe_file_if.sv
// interface carrying the file register port between executor and storage
`timescale 1ns/1ps
interface bsoe_file_if;
   import bsoe_pkg::*;
   logic en;
   logic [FILE_AW-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic we;
   logic [FILE_AW-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   modport ctrl (output en, output rd_addr, input rd_data, output we, output wr_addr, output wr_data);
   modport mem (input en, input rd_addr, output rd_data, input we, input wr_addr, input wr_data);
endinterface

// File: bsoe_file_mem.sv
// file register storage, 128 x 8, registered read data
`timescale 1ns/1ps
module bsoe_file_mem
   import bsoe_pkg::*;
(
   input wire logic mclk_in,
   bsoe_file_if.mem port
);
   logic [DATA_W-1:0] mem_reg [0:(1 << FILE_AW)-1];
   logic [DATA_W-1:0] rd_data_reg;

   always_ff @(posedge mclk_in) begin
      if (port.en) begin
         if (port.we) begin
            mem_reg[port.wr_addr] <= port.wr_data;
         end
         rd_data_reg <= port.rd_addr == port.wr_addr && port.we ? port.wr_data : mem_reg[port.rd_addr];
      end
   end

   assign port.rd_data = rd_data_reg;
endmodule

// File: bsoe_executor.sv
// executor for skip, jump, increment and inclusive-or instructions of the core
// Operation
// [RULE1] destination bit 0 writes work register, 1 writes the addressed file register
// [RULE2] decrement-skip-zero stores f-1; zero result skips next, two cycles, flags untouched
// [RULE3] increment-skip-zero stores f+1; zero result skips next, two cycles, flags untouched
// [RULE4] jump loads its 11-bit literal into pc bits 10:0, flags untouched
// [RULE5] jump fills pc bits 14:11 from high latch bits 6:3
// [RULE6] jump always takes two instruction cycles
// [RULE7] or-literal ors work with 8-bit literal into work, updates zero flag
// [RULE8] or-with-file ors work with file, routes per destination, updates zero flag
// [RULE9] increment-file stores f+1 per destination, zero flag set exactly on zero result
// [RULE10] or, increment and non-skipping skips take one cycle, flow continues sequentially
`timescale 1ns/1ps
module bsoe_executor
   import bsoe_pkg::*;
(
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic instr_valid_in,
   input wire logic [INSTR_W-1:0] instr_in,
   input wire logic [LATCH_W-1:0] pc_high_latch_in,
   output logic instr_ready_out,
   output logic [PC_W-1:0] pc_out,
   output logic [DATA_W-1:0] work_out,
   output logic zero_flag_out,
   output logic done_out,
   output logic [1:0] cycles_out,
   output logic skipped_out
);
   bsoe_file_if fbus ();

   bsoe_file_mem u_mem (
      .mclk_in(mclk_in),
      .port(fbus.mem)
   );

   bsoe_state_e state_reg, state_next;
   logic [INSTR_W-1:0] instr_reg;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [DATA_W-1:0] work_reg, work_next;
   logic zero_reg, zero_next;
   logic done_reg, done_next;
   logic [1:0] cycles_reg, cycles_next;
   logic skipped_reg, skipped_next;

   // decode of the incoming word
   wire accept = ce_in && instr_valid_in && (state_reg == ST_IDLE);
   wire [5:0] in_op6 = instr_in[INSTR_W-1:INSTR_W-6];
   wire [2:0] in_op3 = instr_in[INSTR_W-1:INSTR_W-3];
   wire in_is_or_lit = (in_op6 == OP_OR_LITERAL_INTO_WORK);
   wire in_is_jump = (in_op3 == OP_JUMP_ABSOLUTE);
   wire in_is_file_op = (in_op6 == OP_DECREMENT_SKIP_ZERO) || (in_op6 == OP_INCREMENT_SKIP_ZERO) ||
                        (in_op6 == OP_INCREMENT_FILE) || (in_op6 == OP_OR_WORK_WITH_FILE);
   wire [DATA_W-1:0] lit8 = instr_in[LIT8_MSB:0];
   wire [DATA_W-1:0] or_lit_result = work_reg | lit8;
   wire [PC_W-1:0] jump_target = {pc_high_latch_in[LATCH_HI_MSB:LATCH_HI_LSB], instr_in[LIT11_MSB:0]}; // RULE4 RULE5

   // decode of the held file instruction, operand now on rd_data
   wire [5:0] op6 = instr_reg[INSTR_W-1:INSTR_W-6];
   wire is_dec_skip = (op6 == OP_DECREMENT_SKIP_ZERO);
   wire is_inc_skip = (op6 == OP_INCREMENT_SKIP_ZERO);
   wire is_inc = (op6 == OP_INCREMENT_FILE);
   wire is_or_file = (op6 == OP_OR_WORK_WITH_FILE);
   wire dest_file = instr_reg[DEST_BIT];
   wire [DATA_W-1:0] operand = fbus.rd_data;
   wire [DATA_W-1:0] dec_result = operand - 8'h01; // RULE2
   wire [DATA_W-1:0] inc_result = operand + 8'h01; // RULE3 RULE9
   wire [DATA_W-1:0] or_file_result = work_reg | operand; // RULE8
   wire [DATA_W-1:0] file_result = is_dec_skip ? dec_result : (is_or_file ? or_file_result : inc_result);
   wire result_zero = bsoe_is_zero(file_result);
   wire take_skip = (is_dec_skip || is_inc_skip) && result_zero; // RULE2 RULE3
   wire in_operand = ce_in && (state_reg == ST_OPERAND);

   // operand is read at the accept edge and stands on rd_data through the operand cycle
   assign fbus.en = ce_in;
   assign fbus.rd_addr = instr_in[FILE_ADDR_MSB:0];
   assign fbus.we = in_operand && dest_file; // RULE1
   assign fbus.wr_addr = instr_reg[FILE_ADDR_MSB:0];
   assign fbus.wr_data = file_result;

   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      work_next = work_reg;
      zero_next = zero_reg;
      done_next = 1'b0;
      cycles_next = cycles_reg;
      skipped_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               if (in_is_jump) begin
                  pc_next = jump_target; // RULE4 RULE5
                  state_next = ST_EXTRA; // RULE6
               end else if (in_is_file_op) begin
                  state_next = ST_OPERAND;
               end else begin
                  pc_next = PC_W'(pc_reg + 15'h0001); // RULE10
                  if (in_is_or_lit) begin
                     work_next = or_lit_result; // RULE7
                     zero_next = bsoe_is_zero(or_lit_result); // RULE7
                  end
                  done_next = 1'b1;
                  cycles_next = CYCLES_ONE;
               end
            end
         end
         ST_OPERAND: begin
            if (!dest_file) begin
               work_next = file_result; // RULE1
            end
            if (is_inc || is_or_file) begin
               zero_next = result_zero; // RULE8 RULE9
            end
            if (take_skip) begin
               pc_next = PC_W'(pc_reg + 15'h0002); // RULE2 RULE3
               state_next = ST_EXTRA;
            end else begin
               pc_next = PC_W'(pc_reg + 15'h0001); // RULE10
               done_next = 1'b1;
               cycles_next = CYCLES_ONE;
               state_next = ST_IDLE;
            end
         end
         ST_EXTRA: begin
            // the replaced or flushed slot executes as a no-operation
            skipped_next = 1'b1;
            done_next = 1'b1;
            cycles_next = CYCLES_TWO; // RULE2 RULE3 RULE6
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // every register has a short process of its own; ce_in low freezes them all
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ST_IDLE;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // the word is held so the operand cycle can still decode it
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         instr_reg <= '0;
      end else if (accept) begin
         instr_reg <= instr_in;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pc_reg <= PC_RESET;
      end else if (ce_in) begin
         pc_reg <= pc_next;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         work_reg <= WORK_RESET;
      end else if (ce_in) begin
         work_reg <= work_next;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         zero_reg <= ZERO_RESET;
      end else if (ce_in) begin
         zero_reg <= zero_next;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_reg <= PULSE_RESET;
      end else if (ce_in) begin
         done_reg <= done_next;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cycles_reg <= CYCLES_RESET;
      end else if (ce_in) begin
         cycles_reg <= cycles_next;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         skipped_reg <= PULSE_RESET;
      end else if (ce_in) begin
         skipped_reg <= skipped_next;
      end
   end

   // ready is registered from the next state: high exactly while the current state is idle
   logic ready_reg;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ready_reg <= READY_RESET;
      end else if (ce_in) begin
         ready_reg <= (state_next == ST_IDLE);
      end
   end

   assign instr_ready_out = ready_reg;
   assign pc_out = pc_reg;
   assign work_out = work_reg;
   assign zero_flag_out = zero_reg;
   assign done_out = done_reg;
   assign cycles_out = cycles_reg;
   assign skipped_out = skipped_reg;
endmodule

// File: bsoe_checker.sv
// checker of executor timing, flags and results at the top ports
`timescale 1ns/1ps
module bsoe_checker
   import bsoe_pkg::*;
(
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic instr_valid_in,
   input wire logic [INSTR_W-1:0] instr_in,
   input wire logic [LATCH_W-1:0] pc_high_latch_in,
   input wire logic instr_ready_out,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic [DATA_W-1:0] work_out,
   input wire logic zero_flag_out,
   input wire logic done_out,
   input wire logic [1:0] cycles_out,
   input wire logic skipped_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in || !ce_in);
   wire take = ce_in && instr_valid_in && instr_ready_out;
   wire [5:0] op = instr_in[13:8];
   wire jmp = take && instr_in[13:11] == OP_JUMP_ABSOLUTE;
   wire skp = take && (op == OP_DECREMENT_SKIP_ZERO || op == OP_INCREMENT_SKIP_ZERO);
   wire inc_or = op == OP_INCREMENT_FILE || op == OP_OR_WORK_WITH_FILE;
   sequence one_end;
      done_out && !skipped_out && cycles_out == CYCLES_ONE;
   endsequence
   sequence two_end;
      !done_out ##1 done_out && skipped_out && cycles_out == CYCLES_TWO;
   endsequence
   jump_pc_a: assert property (jmp |=> pc_out == {$past(pc_high_latch_in[6:3]), $past(instr_in[10:0])})
      else $error("jump pc wrong");
   jump_cycles_a: assert property (jmp |=> two_end)
      else $error("jump timing wrong");
   skip_timing_a: assert property (skp |=> !done_out ##1 (one_end or two_end))
      else $error("skip timing wrong");
   flags_kept_a: assert property (skp || jmp |=> $stable(zero_flag_out) [*2])
      else $error("zero flag changed");
   or_literal_a: assert property (take && op == OP_OR_LITERAL_INTO_WORK |=> one_end ##0
      work_out == ($past(work_out) | $past(instr_in[7:0])) && zero_flag_out == (work_out == 8'h00))
      else $error("literal or wrong");
   file_zero_a: assert property (take && inc_or && !instr_in[DEST_BIT] |=>
      !done_out ##1 one_end ##0 zero_flag_out == (work_out == 8'h00))
      else $error("file op zero flag wrong");
   dest_file_a: assert property (take && (skp || inc_or) && instr_in[DEST_BIT] |=> $stable(work_out) [*2])
      else $error("work changed on file destination");
   pc_step_a: assert property (one_end |-> pc_out == $past(pc_out) + 15'h0001)
      else $error("pc did not step by one");
endmodule
bind bsoe_executor bsoe_checker chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
   .instr_valid_in(instr_valid_in), .instr_in(instr_in), .pc_high_latch_in(pc_high_latch_in),
   .instr_ready_out(instr_ready_out), .pc_out(pc_out), .work_out(work_out), .zero_flag_out(zero_flag_out),
   .done_out(done_out), .cycles_out(cycles_out), .skipped_out(skipped_out));

// File: bsoe_tb.sv
// self-checking bench for the skip, jump and or executor
`timescale 1ns/1ps
module tb;
   import bsoe_pkg::*;
   typedef struct packed {logic [13:0] ins; logic [6:0] lat; logic [7:0] w; logic z; logic [1:0] cyc; logic sk;} bsoe_row_s;
   localparam logic [28:0] RST_VIEW = {15'h0000, 8'h00, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0};
   logic mclk_in = 1'h0;
   logic arst_n = 1'h0;
   logic valid = 1'h0;
   logic ce = 1'h1;
   logic [INSTR_W-1:0] instr = 14'h0000;
   logic [LATCH_W-1:0] latch = 7'h00;
   logic ready, zero, done, skipped;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] pc_e = 15'h0000;
   logic [DATA_W-1:0] work;
   logic [1:0] cycles;
   int miscompares = 0;
   int n_compared = 0;
   // file 5 is seeded through an or with work all ones, then walked across zero
   bsoe_row_s rows [11] = '{
      '{14'h3800, 7'h00, 8'h00, 1'h1, 2'h1, 1'h0},
      '{14'h38FF, 7'h00, 8'hFF, 1'h0, 2'h1, 1'h0},
      '{14'h0485, 7'h00, 8'hFF, 1'h0, 2'h1, 1'h0},
      '{14'h0A05, 7'h00, 8'h00, 1'h1, 2'h1, 1'h0},
      '{14'h0F85, 7'h00, 8'h00, 1'h1, 2'h2, 1'h1},
      '{14'h0B05, 7'h00, 8'hFF, 1'h1, 2'h1, 1'h0},
      '{14'h0A85, 7'h00, 8'hFF, 1'h0, 2'h1, 1'h0},
      '{14'h0B05, 7'h00, 8'h00, 1'h0, 2'h2, 1'h1},
      '{14'h0405, 7'h00, 8'h01, 1'h0, 2'h1, 1'h0},
      '{14'h2DA3, 7'h55, 8'h01, 1'h0, 2'h2, 1'h1},
      '{14'h0000, 7'h7F, 8'h01, 1'h0, 2'h1, 1'h0}};
   // after a reset that cut a skip short, file 5 must still hold 01
   bsoe_row_s after_rst = '{14'h0405, 7'h00, 8'h01, 1'h0, 2'h1, 1'h0};
   wire [28:0] view = {pc, work, zero, ready, done, cycles, skipped};
   always #10 mclk_in = ~mclk_in;
   bsoe_executor dut (.mclk_in(mclk_in), .arst_n_in(arst_n), .ce_in(ce), .instr_valid_in(valid), .instr_in(instr),
      .pc_high_latch_in(latch), .instr_ready_out(ready), .pc_out(pc), .work_out(work), .zero_flag_out(zero),
      .done_out(done), .cycles_out(cycles), .skipped_out(skipped));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic run(input bsoe_row_s r);
      int n;
      int lat_e;
      n = 0;
      // extra negedges before done: one for a file operand read, one for a second cycle
      lat_e = (r.cyc == 2'h2) ? 1 : 0;
      if (r.ins[13:12] == 2'h0 && (r.ins[11:8] == 4'hA || r.ins[11:8] == 4'hB ||
          r.ins[11:8] == 4'hF || r.ins[11:8] == 4'h4)) begin
         lat_e++;
      end
      valid = 1'h1;
      instr = r.ins;
      latch = r.lat;
      @(negedge mclk_in);
      valid = 1'h0;
      while (done !== 1'h1 && n < 6) begin
         @(negedge mclk_in);
         n++;
      end
      pc_e = (r.ins[13:11] == OP_JUMP_ABSOLUTE) ? {r.lat[6:3], r.ins[10:0]} : pc_e + 15'(r.cyc);
      chk(32'(n), 32'(lat_e));
      chk(32'(view), 32'({pc_e, r.w, r.z, 2'h3, r.cyc, r.sk}));
      @(negedge mclk_in);
   endtask
   initial begin
      repeat (6) @(negedge mclk_in);
      chk(32'(view), 32'(RST_VIEW));
      arst_n = 1'h1;
      foreach (rows[i]) run(rows[i]);
      // reset in the middle of a skip must abort it
      valid = 1'h1;
      instr = 14'h0F85;
      @(negedge mclk_in);
      arst_n = 1'h0;
      valid = 1'h0;
      @(negedge mclk_in);
      chk(32'(view), 32'(RST_VIEW));
      arst_n = 1'h1;
      @(negedge mclk_in);
      chk(32'(view), 32'(RST_VIEW));
      pc_e = 15'h0000;
      run(after_rst);
      // ce low freezes acceptance and an instruction in flight
      ce = 1'h0;
      valid = 1'h1;
      instr = 14'h38F0;
      repeat (2) @(negedge mclk_in);
      chk(32'(view), 32'({15'h0001, 8'h01, 1'h0, 1'h1, 1'h0, 2'h1, 1'h0}));
      ce = 1'h1;
      @(negedge mclk_in);
      valid = 1'h0;
      chk(32'(view), 32'({15'h0002, 8'hF1, 1'h0, 1'h1, 1'h1, 2'h1, 1'h0}));
      @(negedge mclk_in);
      valid = 1'h1;
      instr = 14'h2DA3;
      latch = 7'h55;
      @(negedge mclk_in);
      valid = 1'h0;
      ce = 1'h0;
      repeat (3) @(negedge mclk_in);
      chk(32'(view), 32'({15'h55A3, 8'hF1, 1'h0, 1'h0, 1'h0, 2'h1, 1'h0}));
      ce = 1'h1;
      @(negedge mclk_in);
      chk(32'(view), 32'({15'h55A3, 8'hF1, 1'h0, 1'h1, 1'h1, 2'h2, 1'h1}));
      stop_test();
   end
   initial begin
      #5000;
      miscompares++;
      stop_test();
   end
endmodule
